// ===== hw/key_id_download_interface.sv
// key identifier download engine with mode coding and three terminal protocols
module key_id_download_interface #(
    parameter int CYC_PER_MS = key_id_pkg::CYC_PER_MS
)(
    input  wire logic                          mclk,           // system clock, 250 MHz
    input  wire logic                          rst,            // synchronous reset, power-on
    input  wire logic                          link_clk,       // terminal-side clock
    input  wire logic                          link_rst,       // synchronous reset, link domain
    input  wire logic                          key_valid,      // valid key present
    input  wire logic [key_id_pkg::KEY_ID_W-1:0] key_id,       // identifier of present key
    input  wire logic                          dip_advanced,   // switch: advanced mode
    output logic                               term_out_a,     // terminal out a
    output logic                               term_out_b_o,   // terminal out b drive value
    output logic                               term_out_b_oe,  // terminal out b drive enable
    input  wire logic                          term_out_b_i,   // terminal out b pin level
    output logic                               term_out_c,     // terminal out c
    output logic                               term_out_d,     // terminal out d
    input  wire logic                          term_in_a,      // terminal in a
    input  wire logic                          term_in_b,      // terminal in b
    output logic                               keylock_lvl,    // controller lock level
    output logic                               ack_lvl,        // controller ack level
    output key_id_pkg::mode_t                  mode_out        // mode in use
);
    import key_id_pkg::*;

    link_if lk();

    term_port u_port (
        .link_clk      (link_clk),
        .link_rst      (link_rst),
        .lk            (lk),
        .term_out_a    (term_out_a),
        .term_out_b_o  (term_out_b_o),
        .term_out_b_oe (term_out_b_oe),
        .term_out_b_i  (term_out_b_i),
        .term_out_c    (term_out_c),
        .term_out_d    (term_out_d),
        .term_in_a     (term_in_a),
        .term_in_b     (term_in_b)
    );

    logic [2:0]           in_meta_r;
    logic [2:0]           in_sync_r;
    logic                 dip_meta_r;
    logic                 dip_sync_r;
    logic [CODE_W-1:0]    code_cnt_r;
    logic                 coded_r;
    mode_t                mode_r;
    state_t               state_r;
    logic [4:0]           idx_r;
    logic [KEY_ID_W-1:0]  shreg_r;
    logic                 up_r;
    logic                 lo_r;
    logic                 data_r;
    logic                 tmr_load_r;
    logic [MS_W-1:0]      tmr_ms_r;
    logic                 tmr_exp;
    logic                 keylock_r;
    logic                 ack_r;
    logic                 req_s;
    logic                 echo_bad;
    logic                 reply_on;

    ms_timer #(
        .CYC_PER_MS (CYC_PER_MS),
        .MS_W       (MS_W)
    ) u_tmr (
        .mclk    (mclk),
        .rst     (rst),
        .load    (tmr_load_r),
        .load_ms (tmr_ms_r),
        .expired (tmr_exp)
    );

    // bit of one half, counted from that half's top
    function automatic logic tx_pick(input logic [KEY_ID_W-1:0] sr, input logic [4:0] idx, input int msb);
        logic [4:0] pos;
        pos = 5'(msb) - idx;
        return sr[pos];
    endfunction

    // second crossing, link domain into mclk
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            in_meta_r  <= 3'h0;
            in_sync_r  <= 3'h0;
            dip_meta_r <= 1'b0;
            dip_sync_r <= 1'b0;
        end
        else
        begin
            in_meta_r  <= {lk.out_b_in, lk.in_b, lk.in_a};
            in_sync_r  <= in_meta_r;
            dip_meta_r <= dip_advanced;
            dip_sync_r <= dip_meta_r;
        end
    end

    // request is on out b in advanced mode, on in a otherwise
    assign req_s    = (mode_r == MODE_ADV) ? in_sync_r[2] : in_sync_r[0];
    assign echo_bad = ({in_sync_r[0], in_sync_r[1]} != {up_r, lo_r});
    assign reply_on = (state_r == HS_WAITLO) || (state_r == HS_HOLD) || (state_r == HS_END);

    // mode coding once after power-on
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            code_cnt_r <= '0;
            coded_r    <= 1'b0;
            mode_r     <= MODE_TX;
        end
        else if (!coded_r)
        begin
            code_cnt_r <= code_cnt_r + 1'b1;
            if (code_cnt_r == CODE_SETTLE_CYC - 1'b1)
            begin
                coded_r <= 1'b1;
                if (dip_sync_r)
                    mode_r <= MODE_ADV;
                else if (in_sync_r[1])
                    mode_r <= MODE_HS;
                else
                    mode_r <= MODE_TX;
            end
        end
    end

    // download sequencer
    always_ff @(posedge mclk)
    begin
        tmr_load_r <= 1'b0;
        if (rst)
        begin
            state_r  <= ST_CODE;
            idx_r    <= 5'h00;
            shreg_r  <= '0;
            up_r     <= 1'b0;
            lo_r     <= 1'b0;
            data_r   <= 1'b0;
            tmr_ms_r <= '0;
        end
        else if (state_r == ST_CODE)
        begin
            if (coded_r)
                state_r <= ST_IDLE;
        end
        else if (!key_valid)
        begin
            state_r <= ST_IDLE;
            idx_r   <= 5'h00;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (mode_r == MODE_TX)
                    begin
                        // TX_DONE is left only via key loss, so a rerun needs reconnection
                        state_r    <= TX_SYNC;
                        shreg_r    <= key_id;
                        idx_r      <= 5'h00;
                        tmr_load_r <= 1'b1;
                        tmr_ms_r   <= T_SYNC_MS;
                    end
                    else if (req_s)
                    begin
                        state_r    <= HS_ACCESS;
                        tmr_load_r <= 1'b1;
                        tmr_ms_r   <= T_ACCESS_MS;
                        if (idx_r == 5'h00)
                        begin
                            shreg_r <= key_id;
                            data_r  <= key_id[UPPER_MSB];
                        end
                        else
                        begin
                            data_r <= shreg_r[UPPER_MSB];
                        end
                    end
                end
                TX_SYNC:
                begin
                    if (tmr_exp)
                    begin
                        state_r    <= TX_LOW;
                        up_r       <= tx_pick(shreg_r, idx_r, UPPER_MSB);
                        lo_r       <= tx_pick(shreg_r, idx_r, LOWER_MSB);
                        tmr_load_r <= 1'b1;
                        tmr_ms_r   <= T_HALF_MS;
                    end
                end
                TX_LOW:
                begin
                    if (tmr_exp)
                    begin
                        state_r    <= TX_HIGH;
                        tmr_load_r <= 1'b1;
                        tmr_ms_r   <= T_HALF_MS;
                    end
                end
                TX_HIGH:
                begin
                    if (tmr_exp)
                    begin
                        tmr_load_r <= 1'b1;
                        if (echo_bad)
                        begin
                            state_r  <= TX_SYNC;
                            shreg_r  <= key_id;
                            idx_r    <= 5'h00;
                            tmr_ms_r <= T_SYNC_MS;
                        end
                        else if (idx_r == 5'(HALF_W - 1))
                        begin
                            state_r <= TX_DONE;
                        end
                        else
                        begin
                            state_r  <= TX_LOW;
                            idx_r    <= idx_r + 1'b1;
                            up_r     <= tx_pick(shreg_r, idx_r + 1'b1, UPPER_MSB);
                            lo_r     <= tx_pick(shreg_r, idx_r + 1'b1, LOWER_MSB);
                            tmr_ms_r <= T_HALF_MS;
                        end
                    end
                end
                TX_DONE:
                begin
                    state_r <= TX_DONE;
                end
                HS_ACCESS:
                begin
                    if (tmr_exp)
                        state_r <= HS_WAITLO;
                end
                HS_WAITLO:
                begin
                    if (!req_s)
                    begin
                        tmr_load_r <= 1'b1;
                        if (idx_r == 5'(KEY_ID_W - 1))
                        begin
                            state_r  <= HS_END;
                            tmr_ms_r <= T_END_MS;
                        end
                        else
                        begin
                            state_r  <= HS_HOLD;
                            tmr_ms_r <= T_HOLD_MS;
                        end
                    end
                end
                HS_HOLD:
                begin
                    if (tmr_exp)
                    begin
                        state_r <= ST_IDLE;
                        idx_r   <= idx_r + 1'b1;
                        shreg_r <= {shreg_r[KEY_ID_W-2:0], 1'b0};
                    end
                end
                HS_END:
                begin
                    if (tmr_exp)
                    begin
                        state_r <= ST_IDLE;
                        idx_r   <= 5'h00;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // terminal mapping per mode
    always_comb
    begin
        lk.out_a    = 1'b0;
        lk.out_b    = 1'b0;
        lk.out_b_oe = 1'b0;
        lk.out_c    = 1'b0;
        lk.out_d    = 1'b0;
        if (!coded_r)
        begin
            lk.out_d = 1'b1;  // coding drive for the jumper test
        end
        else
        begin
            case (mode_r)
                MODE_TX:
                begin
                    lk.out_a    = (state_r == TX_SYNC);
                    lk.out_b    = (state_r == TX_HIGH);
                    lk.out_b_oe = 1'b1;
                    lk.out_c    = up_r && ((state_r == TX_LOW) || (state_r == TX_HIGH));
                    lk.out_d    = lo_r && ((state_r == TX_LOW) || (state_r == TX_HIGH));
                end
                MODE_HS:
                begin
                    lk.out_a    = key_valid;
                    lk.out_b    = reply_on;
                    lk.out_b_oe = 1'b1;
                    lk.out_c    = data_r;
                    lk.out_d    = 1'b1;
                end
                MODE_ADV:
                begin
                    lk.out_a = reply_on;
                    lk.out_c = data_r;
                    lk.out_d = key_valid;
                end
                default:
                begin
                    lk.out_a = 1'b0;
                end
            endcase
        end
    end

    // lock and ack pass-through in advanced mode
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            keylock_r <= 1'b0;
            ack_r     <= 1'b0;
        end
        else
        begin
            keylock_r <= coded_r && (mode_r == MODE_ADV) && in_sync_r[0];
            ack_r     <= coded_r && (mode_r == MODE_ADV) && in_sync_r[1];
        end
    end

    assign keylock_lvl = keylock_r;
    assign ack_lvl     = ack_r;
    assign mode_out    = mode_r;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_mode_frozen: assert property ($past(coded_r) |-> $stable(mode_r))
        else $error("mode changed after coding");
    chk_tx_autostart: assert property (
        (state_r == ST_IDLE && mode_r == MODE_TX && key_valid) |=> state_r == TX_SYNC)
        else $error("transmitter mode did not start on key");
    chk_key_loss: assert property (
        (state_r != ST_CODE && !key_valid) |=> (state_r == ST_IDLE && idx_r == 5'h00))
        else $error("transfer kept after key loss");
    chk_reload_id: assert property (
        (state_r == TX_SYNC && $past(state_r) != TX_SYNC) |-> shreg_r == $past(key_id))
        else $error("identifier not reloaded at start");
    chk_echo_restart: assert property (
        (state_r == TX_HIGH && tmr_exp && echo_bad && key_valid) |=> state_r == TX_SYNC)
        else $error("echo mismatch did not restart");
    chk_no_unsolicited: assert property (
        (mode_r != MODE_TX && state_r == ST_IDLE && !req_s && key_valid) |=> !reply_on)
        else $error("reply without request");
    chk_reply_rise: assert property ($rose(reply_on) |-> $past(req_s, 2))
        else $error("reply rose without request");
    chk_reply_hold: assert property (
        (state_r == HS_WAITLO && !req_s && key_valid && idx_r == 5'(KEY_ID_W - 1)) |=> reply_on [*2])
        else $error("end marker missing");
    chk_half_limit: assert property (
        (state_r == TX_LOW || state_r == TX_HIGH) |-> idx_r < 5'(HALF_W))
        else $error("transmit index beyond half width");
    chk_msb_first: assert property (
        (state_r == HS_ACCESS && $past(state_r) == ST_IDLE && $past(idx_r) == 5'h00)
        |-> data_r == $past(key_id[UPPER_MSB]))
        else $error("first bit is not the top bit");

    cov_tx_done: cover property (state_r == TX_HIGH ##1 state_r == TX_DONE);
    cov_tx_retry: cover property (state_r == TX_HIGH ##1 state_r == TX_SYNC);
    cov_hs_end: cover property (state_r == HS_END ##1 state_r == ST_IDLE);
    cov_adv_mode: cover property (coded_r && mode_r == MODE_ADV && reply_on);
endmodule

// ===== hw/key_id_pkg.sv
// constants and types of the key identifier download block
package key_id_pkg;
    localparam int KEY_ID_W    = 28;
    localparam int CLASS_MSB   = 27;
    localparam int CLASS_LSB   = 24;
    localparam int SERIAL_MSB  = 23;
    localparam int HALF_W      = 14;
    localparam int UPPER_MSB   = 27;
    localparam int LOWER_MSB   = 13;
    localparam int MCLK_MHZ    = 250;
    localparam int MCLK_HZ     = MCLK_MHZ * 1000000;
    localparam int MS_PER_S    = 1000;
    localparam int CYC_PER_MS  = (MCLK_HZ + MS_PER_S - 1) / MS_PER_S;
    localparam int MS_W        = 8;
    localparam logic [MS_W-1:0] T_SYNC_MS   = 8'd100;
    localparam logic [MS_W-1:0] T_BIT_MS    = 8'd100;
    localparam logic [MS_W-1:0] T_HALF_MS   = T_BIT_MS / 2;
    localparam logic [MS_W-1:0] T_ACCESS_MS = 8'd10;
    localparam logic [MS_W-1:0] T_HOLD_MS   = 8'd10;
    localparam logic [MS_W-1:0] T_END_MS    = 8'd200;
    localparam int CODE_SETTLE_NS  = 2000;
    localparam int CODE_W          = 10;
    localparam logic [CODE_W-1:0] CODE_SETTLE_CYC = CODE_W'(CODE_SETTLE_NS * MCLK_MHZ / 1000);

    typedef enum logic [1:0] {
        MODE_TX  = 2'b00,
        MODE_HS  = 2'b01,
        MODE_ADV = 2'b10
    } mode_t;

    typedef enum logic [3:0] {
        ST_CODE    = 4'b0000,
        ST_IDLE    = 4'b0001,
        TX_SYNC    = 4'b0010,
        TX_LOW     = 4'b0011,
        TX_HIGH    = 4'b0100,
        TX_DONE    = 4'b0101,
        HS_ACCESS  = 4'b0110,
        HS_WAITLO  = 4'b0111,
        HS_HOLD    = 4'b1000,
        HS_END     = 4'b1001
    } state_t;
endpackage

// ===== hw/link_if.sv
// terminal levels passed between the core and the link-clock port logic
interface link_if;
    logic out_a;
    logic out_b;
    logic out_b_oe;
    logic out_c;
    logic out_d;
    logic in_a;
    logic in_b;
    logic out_b_in;

    modport core
    (
        output out_a, out_b, out_b_oe, out_c, out_d,
        input  in_a, in_b, out_b_in
    );
    modport port
    (
        input  out_a, out_b, out_b_oe, out_c, out_d,
        output in_a, in_b, out_b_in
    );
endinterface

// ===== hw/ms_timer.sv
// millisecond down-counter fed by a cycle prescaler
module ms_timer #(
    parameter int CYC_PER_MS = key_id_pkg::CYC_PER_MS,
    parameter int MS_W       = key_id_pkg::MS_W
)(
    input  wire logic            mclk,     // system clock
    input  wire logic            rst,      // synchronous reset
    input  wire logic            load,     // restart with load_ms
    input  wire logic [MS_W-1:0] load_ms,  // interval in ms
    output logic                 expired   // interval elapsed
);
    localparam int PRE_W = $clog2(CYC_PER_MS + 1);
    localparam logic [PRE_W-1:0] PRE_TOP = PRE_W'(CYC_PER_MS - 1);

    logic [PRE_W-1:0] pre_r;
    logic [MS_W-1:0]  ms_r;

    // prescaled millisecond count
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pre_r <= '0;
            ms_r  <= '0;
        end
        else if (load)
        begin
            pre_r <= PRE_TOP;
            ms_r  <= load_ms;
        end
        else if (ms_r != '0)
        begin
            if (pre_r == '0)
            begin
                pre_r <= PRE_TOP;
                ms_r  <= ms_r - 1'b1;
            end
            else
            begin
                pre_r <= pre_r - 1'b1;
            end
        end
    end

    assign expired = (ms_r == '0) && !load;
endmodule

// ===== hw/term_port.sv
// link-clock side: synchronises terminal inputs and registers terminal outputs
module term_port (
    input  wire logic link_clk,       // link clock
    input  wire logic link_rst,       // synchronous reset, link domain
    link_if.port      lk,             // core side levels
    output logic      term_out_a,     // terminal out a
    output logic      term_out_b_o,   // terminal out b drive value
    output logic      term_out_b_oe,  // terminal out b drive enable
    input  wire logic term_out_b_i,   // terminal out b pin level
    output logic      term_out_c,     // terminal out c
    output logic      term_out_d,     // terminal out d
    input  wire logic term_in_a,      // terminal in a
    input  wire logic term_in_b       // terminal in b
);
    logic [4:0] o_meta_r;
    logic [4:0] o_sync_r;
    logic [2:0] i_meta_r;
    logic [2:0] i_sync_r;

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            o_meta_r <= 5'h00;
            o_sync_r <= 5'h00;
        end
        else
        begin
            o_meta_r <= {lk.out_d, lk.out_c, lk.out_b_oe, lk.out_b, lk.out_a};
            o_sync_r <= o_meta_r;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            i_meta_r <= 3'h0;
            i_sync_r <= 3'h0;
        end
        else
        begin
            i_meta_r <= {term_out_b_i, term_in_b, term_in_a};
            i_sync_r <= i_meta_r;
        end
    end

    assign term_out_a    = o_sync_r[0];
    assign term_out_b_o  = o_sync_r[1];
    assign term_out_b_oe = o_sync_r[2];
    assign term_out_c    = o_sync_r[3];
    assign term_out_d    = o_sync_r[4];
    assign lk.in_a       = i_sync_r[0];
    assign lk.in_b       = i_sync_r[1];
    assign lk.out_b_in   = i_sync_r[2];
endmodule

// ===== testbench/ctrl_model.sv
// controller model: echoes strobed bits and runs the bit request handshake
module ctrl_model (
    input  wire logic   out_a,  // sync
    input  wire logic   out_b,  // strobe or reply
    input  wire logic   out_c,  // data
    input  wire logic   out_d,  // lower data or coding drive
    input  wire logic   hs,     // jumper fitted
    input  wire logic   flip,   // corrupt first echo
    input  wire logic   go,     // start a download
    output logic        in_a,   // echo or request
    output logic        in_b,   // echo or coding sense
    output logic        busy,   // download running
    output logic [27:0] got,    // collected identifier
    output int          syncs   // sync pulses seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ea = 0;
    logic eb = 0;
    logic req = 0;
    logic used = 0;
    int k;
    int n;
    assign in_a = hs ? req : ea;
    assign in_b = hs ? out_d : eb;
    initial
    begin
        busy = 0;
        got = 0;
        syncs = 0;
    end
    always @(posedge out_a)
        if (!hs)
            syncs++;
    always @(posedge out_b)
        if (!hs)
        begin
            ea = out_c ^ (flip & !used);
            eb = out_d;
            used = 1;
            got = {got[26:14], out_c, got[12:0], out_d};
        end
    // echo lines go back to 0 once the check is over
    always @(negedge out_b)
    begin
        #2000;
        ea = 0;
        eb = 0;
    end
    always @(posedge go)
    begin
        busy = 1;
        for (n = 0; n < 28; n++)
        begin
            req = 1;
            for (k = 0; k < 500 && out_b !== 1; k++) #100;
            got = {got[26:0], out_c};
            #300 req = 0;
            for (k = 0; k < 500 && n < 27 && out_b !== 0; k++) #100;
            #300;
        end
        busy = 0;
    end
endmodule

// ===== testbench/tb_key_id_download_interface.sv
// self-checking bench for the key identifier download block
module tb_key_id_download_interface;
    timeunit 1ns;
    timeprecision 100ps;
    import key_id_pkg::*;
    localparam int CPM = 25;
    localparam int MS = CPM * 4;
    logic mclk = 0, rst = 1, link_clk = 0, link_rst = 1, key_valid = 0, dip = 0, adv = 0;
    logic hs = 0, flip = 0, go = 0, lock = 0, ack = 0, areq = 0;
    logic [27:0] key_id = 28'h0000000;
    logic ta, tbo, tboe, tc, td, pa, pb, busy, kl, al;
    logic [27:0] got;
    int syncs;
    mode_t mode;
    int err_count = 0;
    int samples_checked = 0;
    wire b_pin = tboe ? tbo : areq;
    always #2 mclk = ~mclk;
    always #62.5 link_clk = ~link_clk;
    key_id_download_interface #(.CYC_PER_MS(CPM)) uut (.mclk(mclk), .rst(rst), .link_clk(link_clk),
        .link_rst(link_rst), .key_valid(key_valid), .key_id(key_id), .dip_advanced(dip), .term_out_a(ta),
        .term_out_b_o(tbo), .term_out_b_oe(tboe), .term_out_b_i(b_pin), .term_out_c(tc), .term_out_d(td),
        .term_in_a(adv ? lock : pa), .term_in_b(adv ? ack : pb), .keylock_lvl(kl), .ack_lvl(al), .mode_out(mode));
    ctrl_model cm (.out_a(ta), .out_b(tbo), .out_c(tc), .out_d(td), .hs(hs), .flip(flip), .go(go),
        .in_a(pa), .in_b(pb), .busy(busy), .got(got), .syncs(syncs));
    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] s);
        samples_checked++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic ms(input int n);
        #(n * MS);
        @(posedge mclk);
        #1;
    endtask
    task automatic power_on(input logic j, input logic d);
        hs = j;
        adv = d;
        dip = d;
        rst = 1;
        link_rst = 1;
        repeat (4) @(posedge mclk);
        #1 rst = 0;
        repeat (40) @(posedge mclk);
        #1 link_rst = 0;
        repeat (700) @(posedge mclk);
        #1;
    endtask
    task automatic tx_run();
        flip = 1;
        key_id = 28'hA5C396E;
        power_on(0, 0);
        chk("mode", MODE_TX, mode);
        key_valid = 1;
        ms(1720);
        chk("sync count", 2, syncs);
        chk("tx id", key_id, got);
        chk("sync after", 0, ta);
        ms(100);
        chk("no repeat", 2, syncs);
        key_valid = 0;
    endtask
    task automatic hs_xfer();
        go = 1;
        #10 go = 0;
        for (int i = 0; i < 1000 && busy !== 0; i++) ms(1);
        chk("hs done", 0, busy);
        if (busy !== 0)
            finish_test();
        chk("hs id", key_id, got);
        ms(150);
        chk("end marker", 1, tbo);
        ms(100);
        chk("end cleared", 0, tbo);
    endtask
    task automatic hs_run();
        key_id = 28'h8123456;
        power_on(1, 0);
        chk("mode", MODE_HS, mode);
        chk("sync idle", 0, ta);
        key_valid = 1;
        ms(50);
        chk("sync level", 1, ta);
        chk("no reply", 0, tbo);
        hs_xfer();
        key_id = 28'h7FEDCBA;
        hs_xfer();
        key_valid = 0;
    endtask
    task automatic adv_run();
        key_id = 28'h9ABCDEF;
        power_on(0, 1);
        dip = 0;
        lock = 1;
        ack = 1;
        key_valid = 1;
        ms(20);
        chk("mode", MODE_ADV, mode);
        chk("out b drive", 0, tboe);
        chk("adv sync", 1, td);
        chk("lock", 1, kl);
        chk("ack", 1, al);
        areq = 1;
        for (int i = 0; i < 50 && ta !== 1; i++) ms(1);
        chk("adv reply", 1, ta);
        chk("adv data", key_id[27], tc);
        areq = 0;
        ms(20);
        chk("adv reply low", 0, ta);
        key_valid = 0;
    endtask
    initial
    begin
        tx_run();
        hs_run();
        adv_run();
        finish_test();
    end
endmodule
